//--- hdl/sys_glue_pkg.sv
// Constants for the system glue block: address windows, register offsets,
// identifier layout and clock monitor timing.
// Assumes an 18-bit global byte address and byte-wide register data.
package sys_glue_pkg;

  localparam int ADDR_W = 18;
  localparam int DATA_W = 8;

  // Global address windows.
  localparam logic [17:0] REG_LOW = 18'h00000;
  localparam logic [17:0] REG_HIGH = 18'h003FF;
  localparam logic [17:0] INFO_LOW = 18'h00400;
  localparam logic [17:0] INFO_HIGH = 18'h0047F;
  localparam logic [17:0] RAM_LOW = 18'h00800;
  localparam logic [17:0] RAM_BASE_M1 = 18'h007FF;
  localparam logic [18:0] FLASH_END_P1 = 19'h40000;
  localparam logic [17:0] FLASH_HIGH = 18'h3FFFF;

  // Memory sizes in bytes.
  localparam logic [17:0] RAM_BYTE_COUNT = 18'h00800;
  localparam logic [18:0] FLASH_BYTE_COUNT = 19'h08000;
  // Implemented flash pages are this many bytes; they fill the whole flash window.
  localparam logic [18:0] FLASH_IMPL_BYTES = 19'h08000;

  // Register offsets inside the register window.
  localparam logic [9:0] OFF_PART_IDENT_HIGH = 10'h01A;
  localparam logic [9:0] OFF_PART_IDENT_LOW = 10'h01B;
  localparam logic [9:0] OFF_MODE = 10'h00B;
  localparam logic [9:0] OFF_MAP_CONTROL_ONE = 10'h013;
  localparam logic [9:0] OFF_CLOCK_CTRL = 10'h039;
  localparam logic [9:0] OFF_IRQ_STATUS = 10'h03A;
  localparam logic [9:0] OFF_IRQ_ENABLE = 10'h03B;
  localparam logic [9:0] OFF_IRQ_CLEAR = 10'h03C;

  // Field positions.
  localparam int MODE_BIT = 7;
  localparam int INFO_ROW_BIT = 0;
  localparam int CLK_SEL_BIT = 0;
  localparam int MON_EN_BIT = 1;
  localparam int EV_ILLEGAL = 0;
  localparam int EV_MON_TIMEOUT = 1;
  localparam int EV_RESERVED = 2;
  localparam int NUM_EVENTS = 3;

  // Identifier layout.
  localparam int ID_MAJ_FAM_LSB = 12;
  localparam int ID_MIN_FAM_LSB = 8;
  localparam int ID_MAJ_MASK_LSB = 4;
  localparam int ID_MIN_MASK_LSB = 0;

  // Reset values.
  localparam logic [7:0] MAP_CONTROL_RESET = 8'h00;
  localparam logic [7:0] CLOCK_CTRL_RESET = 8'h00;
  localparam logic [2:0] IRQ_ENABLE_RESET = 3'h0;

  // Clock monitor timeout.
  localparam int CLK_MHZ = 100;
  localparam int MON_TIMEOUT_US = 50;
  localparam int MON_TIMEOUT_CYC = MON_TIMEOUT_US * CLK_MHZ;

endpackage : sys_glue_pkg

//--- hdl/sys_glue.sv
// System glue: global address decode, identifier registers, chip mode latch,
// clock source select and oscillator monitor with reset request.
// Assumes one bus master per cycle; the oscillator tick is synchronised into this domain here.
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/100ps

module sys_glue #(
  parameter logic [3:0] MAJOR_FAMILY = 4'h5, // Arbitrary value.
  parameter logic [3:0] MINOR_FAMILY = 4'hA, // Arbitrary value.
  parameter logic [3:0] MAJOR_MASK = 4'h1, // Arbitrary value.
  parameter logic [3:0] MINOR_MASK = 4'h2, // Arbitrary value.
  parameter int MON_TIMEOUT_CYCLES = sys_glue_pkg::MON_TIMEOUT_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Pins
  input wire logic mode_select_pin,
  input wire logic osc_tick,
  // Global bus from the masters
  input wire logic [17:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  // Memory selects
  output logic sel_reg,
  output logic sel_info,
  output logic sel_ram,
  output logic sel_flash,
  // Clock and reset control, interrupt request
  output logic clock_src_osc,
  output logic flash_clk_is_bus,
  output logic illegal_reset_req,
  output logic monitor_reset_req,
  output logic irq
);

  logic [1:0] mode_sync_q;
  logic [1:0] osc_sync_q;
  logic mode_q;
  logic mode_taken_q;
  logic [7:0] map_q;
  logic [7:0] clkctl_q;
  logic [2:0] status_q;
  logic [2:0] enable_q;
  logic [7:0] rdata_q;
  logic osc_prev_q;
  logic [31:0] mon_cnt_q;
  logic illegal_q;
  logic mon_rst_q;
  logic [15:0] part_ident;
  logic in_reg, in_infowin, in_ram, in_flash, flash_impl, reserved;
  logic [9:0] off;
  logic [2:0] event_now;
  logic osc_edge;
  logic clear_hit;

  assign part_ident = {MAJOR_FAMILY, MINOR_FAMILY, MAJOR_MASK, MINOR_MASK};
  assign off = addr[9:0];

  // Decode.
  assign in_reg = (addr <= sys_glue_pkg::REG_HIGH);
  assign in_infowin = (addr >= sys_glue_pkg::INFO_LOW) && (addr <= sys_glue_pkg::INFO_HIGH);
  assign in_ram = (addr >= sys_glue_pkg::RAM_LOW)
                  && (addr <= 18'(sys_glue_pkg::RAM_BASE_M1 + sys_glue_pkg::RAM_BYTE_COUNT));
  assign in_flash = ({1'b0, addr} >= (sys_glue_pkg::FLASH_END_P1 - sys_glue_pkg::FLASH_BYTE_COUNT))
                    && (addr <= sys_glue_pkg::FLASH_HIGH);
  assign flash_impl = ({1'b0, addr} >= (sys_glue_pkg::FLASH_END_P1 - sys_glue_pkg::FLASH_IMPL_BYTES));
  assign reserved = !in_reg && !in_ram && !in_flash
                    && !(in_infowin && map_q[sys_glue_pkg::INFO_ROW_BIT]);

  assign sel_reg = in_reg && (rd || wr);
  assign sel_info = in_infowin && map_q[sys_glue_pkg::INFO_ROW_BIT] && (rd || wr);
  assign sel_ram = in_ram && (rd || wr);
  assign sel_flash = in_flash && flash_impl && (rd || wr);

  assign clock_src_osc = clkctl_q[sys_glue_pkg::CLK_SEL_BIT];
  // Flash and its program timing run from the bus clock, which is clk here.
  assign flash_clk_is_bus = 1'b1;
  assign illegal_reset_req = illegal_q;
  assign monitor_reset_req = mon_rst_q;
  assign rdata = rdata_q;
  assign irq = |(status_q & enable_q);

  // Mode pin synchroniser. It has no reset on purpose: it must keep sampling
  // the strap while reset is high, so that the first edge after release sees
  // the settled pin level and not a reset value.
  always_ff @(posedge clk)
  begin
    mode_sync_q <= {mode_sync_q[0], mode_select_pin};
  end

  // Oscillator tick synchroniser.
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      osc_sync_q <= 2'h0;
    else
      osc_sync_q <= {osc_sync_q[0], osc_tick};
  end

  // The pin is captured once at the first edge after release; later writes
  // may only move from special to normal mode, never back.
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      mode_q <= 1'b0;
      mode_taken_q <= 1'b0;
    end
    else if (!mode_taken_q)
    begin
      mode_q <= mode_sync_q[1];
      mode_taken_q <= 1'b1;
    end
    else if (wr && in_reg && off == sys_glue_pkg::OFF_MODE && !mode_q && wdata[sys_glue_pkg::MODE_BIT])
    begin
      mode_q <= 1'b1;
    end
  end

  // Control registers; identifier writes fall through and are ignored.
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      map_q <= sys_glue_pkg::MAP_CONTROL_RESET;
      clkctl_q <= sys_glue_pkg::CLOCK_CTRL_RESET;
      enable_q <= sys_glue_pkg::IRQ_ENABLE_RESET;
    end
    else if (wr && in_reg)
    begin
      unique case (off)
        sys_glue_pkg::OFF_MAP_CONTROL_ONE: map_q <= {7'h00, wdata[sys_glue_pkg::INFO_ROW_BIT]};
        sys_glue_pkg::OFF_CLOCK_CTRL: clkctl_q <= {6'h00, wdata[1:0]};
        sys_glue_pkg::OFF_IRQ_ENABLE: enable_q <= wdata[2:0];
        default: ;
      endcase
    end
  end

  // Read data, one cycle after the strobe; reserved and unmapped read zero.
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      rdata_q <= 8'h00;
    else if (rd && in_reg)
    begin
      unique case (off)
        sys_glue_pkg::OFF_PART_IDENT_HIGH: rdata_q <= part_ident[15:8];
        sys_glue_pkg::OFF_PART_IDENT_LOW: rdata_q <= part_ident[7:0];
        sys_glue_pkg::OFF_MODE: rdata_q <= {mode_q, 7'h00};
        sys_glue_pkg::OFF_MAP_CONTROL_ONE: rdata_q <= map_q;
        sys_glue_pkg::OFF_CLOCK_CTRL: rdata_q <= clkctl_q;
        sys_glue_pkg::OFF_IRQ_STATUS: rdata_q <= {5'h00, status_q};
        sys_glue_pkg::OFF_IRQ_ENABLE: rdata_q <= {5'h00, enable_q};
        default: rdata_q <= 8'h00;
      endcase
    end
    else
      rdata_q <= 8'h00;
  end

  // Illegal flash page reset request, one cycle pulse.
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      illegal_q <= 1'b0;
    else
      illegal_q <= (rd || wr) && in_flash && !flash_impl;
  end

  // Oscillator monitor; counts bus clocks between oscillator edges.
  assign osc_edge = osc_sync_q[1] ^ osc_prev_q;
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      osc_prev_q <= 1'b0;
      mon_cnt_q <= 32'h0;
      mon_rst_q <= 1'b0;
    end
    else
    begin
      osc_prev_q <= osc_sync_q[1];
      mon_rst_q <= 1'b0;
      if (!clkctl_q[sys_glue_pkg::MON_EN_BIT] || osc_edge)
        mon_cnt_q <= 32'h0;
      else if (mon_cnt_q == 32'(MON_TIMEOUT_CYCLES - 1))
      begin
        mon_cnt_q <= 32'h0;
        mon_rst_q <= 1'b1;
      end
      else
        mon_cnt_q <= mon_cnt_q + 32'h1;
    end
  end

  assign event_now[sys_glue_pkg::EV_ILLEGAL] = (rd || wr) && in_flash && !flash_impl;
  assign event_now[sys_glue_pkg::EV_MON_TIMEOUT] = clkctl_q[sys_glue_pkg::MON_EN_BIT] && !osc_edge
                                                  && mon_cnt_q == 32'(MON_TIMEOUT_CYCLES - 1);
  assign event_now[sys_glue_pkg::EV_RESERVED] = (rd || wr) && reserved;

  // A write of ones to the clear register drops the matching status bits.
  assign clear_hit = wr && in_reg && (off == sys_glue_pkg::OFF_IRQ_CLEAR);

  // Sticky status, one flop per event. A new event wins over a clear in the
  // same cycle, so software can never lose an event that it has not seen.
  for (genvar i = 0; i < sys_glue_pkg::NUM_EVENTS; i++)
  begin : g_status
    always_ff @(posedge clk or posedge reset)
    begin
      if (reset)
        status_q[i] <= 1'b0;
      else if (event_now[i])
        status_q[i] <= 1'b1;
      else if (clear_hit && wdata[i])
        status_q[i] <= 1'b0;
    end

    a_status_sticky: assert property (@(posedge clk) disable iff (reset)
      status_q[i] && !(clear_hit && wdata[i]) |=> status_q[i])
      else $error("status bit dropped without clear");

    a_event_sets: assert property (@(posedge clk) disable iff (reset)
      event_now[i] |=> status_q[i])
      else $error("event did not set status");

    a_clear_drops: assert property (@(posedge clk) disable iff (reset)
      clear_hit && wdata[i] && !event_now[i] |=> !status_q[i])
      else $error("status bit not cleared");
  end

  a_reserved_reads_zero: assert property (@(posedge clk) disable iff (reset)
    rd && reserved |=> rdata == 8'h00)
    else $error("reserved read not zero");

  a_ident_high_value: assert property (@(posedge clk) disable iff (reset)
    rd && in_reg && off == sys_glue_pkg::OFF_PART_IDENT_HIGH |=> rdata == part_ident[15:8])
    else $error("ident high wrong");

  a_ident_low_value: assert property (@(posedge clk) disable iff (reset)
    rd && in_reg && off == sys_glue_pkg::OFF_PART_IDENT_LOW |=> rdata == part_ident[7:0])
    else $error("ident low wrong");

  a_info_gated: assert property (@(posedge clk) disable iff (reset)
    sel_info |-> map_q[sys_glue_pkg::INFO_ROW_BIT])
    else $error("info row selected while off");

  a_reg_window: assert property (@(posedge clk) disable iff (reset)
    sel_reg |-> addr <= 18'h003FF)
    else $error("register select outside window");

  a_info_window: assert property (@(posedge clk) disable iff (reset)
    sel_info |-> addr >= 18'h00400 && addr <= 18'h0047F)
    else $error("info row select outside window");

  a_map_one_bit: assert property (@(posedge clk) disable iff (reset)
    map_q[7:1] == 7'h00)
    else $error("map control spare bits set");

  a_ram_window: assert property (@(posedge clk) disable iff (reset)
    sel_ram |-> addr >= 18'h00800 && addr <= 18'h00FFF)
    else $error("ram decode wrong");

  a_flash_window: assert property (@(posedge clk) disable iff (reset)
    sel_flash |-> addr >= 18'h38000)
    else $error("flash decode wrong");

  a_sel_exclusive: assert property (@(posedge clk) disable iff (reset)
    $onehot0({sel_reg, sel_info, sel_ram, sel_flash}))
    else $error("more than one window selected");

  a_reserved_no_select: assert property (@(posedge clk) disable iff (reset)
    (rd || wr) && reserved |-> !(sel_reg || sel_info || sel_ram || sel_flash))
    else $error("reserved access selected a window");

  a_reserved_write_quiet: assert property (@(posedge clk) disable iff (reset)
    wr && reserved && mode_taken_q |=> $stable(map_q) && $stable(clkctl_q) && $stable(enable_q) && $stable(mode_q))
    else $error("reserved write changed state");

  a_rdata_idle: assert property (@(posedge clk) disable iff (reset)
    !rd |=> rdata == 8'h00)
    else $error("read data outside read cycle");

  a_illegal_reset: assert property (@(posedge clk) disable iff (reset)
    (rd || wr) && in_flash && !flash_impl |=> illegal_reset_req)
    else $error("no illegal reset");

  a_mode_capture: assert property (@(posedge clk) disable iff (reset)
    !mode_taken_q |=> mode_q == $past(mode_sync_q[1]))
    else $error("mode not captured");

  a_mode_no_back: assert property (@(posedge clk) disable iff (reset)
    mode_taken_q && mode_q |=> mode_q)
    else $error("mode left normal");

  a_mode_write_special: assert property (@(posedge clk) disable iff (reset)
    mode_taken_q && !mode_q && !(wr && in_reg && off == sys_glue_pkg::OFF_MODE) |=> !mode_q)
    else $error("mode changed without write");

  a_mode_normal_pin: assert property (@(posedge clk) disable iff (reset)
    !mode_taken_q && mode_sync_q[1] |=> mode_q)
    else $error("normal mode missed");

  a_clock_select: assert property (@(posedge clk) disable iff (reset)
    clock_src_osc == clkctl_q[sys_glue_pkg::CLK_SEL_BIT])
    else $error("clock select mismatch");

  a_clkctl_bits: assert property (@(posedge clk) disable iff (reset)
    clkctl_q[7:2] == 6'h00)
    else $error("clock control spare bits set");

  a_monitor_reset: assert property (@(posedge clk) disable iff (reset)
    monitor_reset_req |-> $past(clkctl_q[sys_glue_pkg::MON_EN_BIT]))
    else $error("monitor reset unarmed");

  a_monitor_quiet: assert property (@(posedge clk) disable iff (reset)
    !clkctl_q[sys_glue_pkg::MON_EN_BIT] |=> !monitor_reset_req)
    else $error("monitor reset while disabled");

  a_monitor_pulse: assert property (@(posedge clk) disable iff (reset)
    monitor_reset_req |=> !monitor_reset_req)
    else $error("monitor reset longer than one cycle");

  a_flash_bus_clock: assert property (@(posedge clk) disable iff (reset)
    flash_clk_is_bus)
    else $error("flash not on bus clock");

  // Main scenarios that the bench is expected to reach.
  c_ident_read: cover property (@(posedge clk) rd && in_reg && off == sys_glue_pkg::OFF_PART_IDENT_HIGH);
  c_info_access: cover property (@(posedge clk) sel_info);
  c_illegal_page: cover property (@(posedge clk) illegal_reset_req);
  c_monitor_fire: cover property (@(posedge clk) monitor_reset_req);
  c_mode_upgrade: cover property (@(posedge clk) mode_taken_q && !mode_q ##1 mode_q);

endmodule : sys_glue

//--- verif/bus_master.sv
// Bus master model standing for the processor and debug masters on the global bus.
// Assumes a slave that never stalls and read data one cycle after the read strobe.
`timescale 1ns/100ps
module bus_master (
  // Clock and returns from the slave
  input wire logic clk,
  input wire logic [7:0] rdata,
  input wire logic [3:0] sels,
  // Request side
  output logic [17:0] addr,
  output logic [7:0] wdata,
  output logic wr,
  output logic rd
);
  initial
  begin
    addr = 18'h00000;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
  end

  // Released write data shows its inverse so that stale data cannot look valid.
  task automatic write_cyc(input logic [17:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    wdata <= ~d;
  endtask : write_cyc

  // Selects are sampled at the edge that takes the read, data 1 ns after that same edge.
  task automatic read_cyc(input logic [17:0] a, output logic [7:0] d, output logic [3:0] s);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    s = sels;
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask : read_cyc
endmodule : bus_master

//--- verif/tb_top.sv
// Self-checking bench for the system glue block.
// Assumes the partner bus master model and a shortened monitor timeout.
`timescale 1ns/100ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin mismatches++; \
  $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module tb_top;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic mode_select_pin = 1'b0;
  logic osc_tick = 1'b0;
  logic osc_run = 1'b1;
  logic [17:0] addr;
  logic [7:0] wdata, rdata, d;
  logic wr, rd;
  logic sel_reg, sel_info, sel_ram, sel_flash, clock_src_osc, flash_clk_is_bus;
  logic illegal_reset_req, monitor_reset_req, irq;
  logic [3:0] s;
  int mismatches = 0;
  int num_checks = 0;
  int n;

  always #5 clk = ~clk;
  always @(posedge clk) if (osc_run) osc_tick <= ~osc_tick;

  sys_glue #(.MAJOR_FAMILY(4'h6), .MINOR_FAMILY(4'h9), .MAJOR_MASK(4'h2), .MINOR_MASK(4'h7),
    .MON_TIMEOUT_CYCLES(16)) dut (.clk(clk), .reset(reset), .mode_select_pin(mode_select_pin),
    .osc_tick(osc_tick), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .sel_reg(sel_reg), .sel_info(sel_info), .sel_ram(sel_ram), .sel_flash(sel_flash),
    .clock_src_osc(clock_src_osc), .flash_clk_is_bus(flash_clk_is_bus),
    .illegal_reset_req(illegal_reset_req), .monitor_reset_req(monitor_reset_req), .irq(irq));

  bus_master master (.clk(clk), .rdata(rdata), .sels({sel_reg, sel_info, sel_ram, sel_flash}),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd));

  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : finish_test

  // Selects are one-hot {reg, info, ram, flash}; data is compared under a mask.
  task automatic rd_chk(input logic [17:0] a, input logic [7:0] m, input logic [7:0] e, input logic [3:0] es);
    master.read_cyc(a, d, s);
    `CHK(d & m, e)
    `CHK(s, es)
  endtask : rd_chk

  // The pin is set while reset is high so it is stable well before release.
  task automatic do_reset(input logic pin);
    @(posedge clk);
    reset <= 1'b1;
    mode_select_pin <= pin;
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    repeat (2) @(posedge clk);
  endtask : do_reset

  initial
  begin
    repeat (3000) @(posedge clk);
    mismatches++;
    finish_test();
  end

  initial
  begin
    do_reset(1'b0);
    rd_chk(18'h0000B, 8'h80, 8'h00, 4'h8);
    master.write_cyc(18'h0000B, 8'h00);
    rd_chk(18'h0000B, 8'h80, 8'h00, 4'h8);
    master.write_cyc(18'h0000B, 8'h80);
    rd_chk(18'h0000B, 8'h80, 8'h80, 4'h8);
    do_reset(1'b1);
    rd_chk(18'h0000B, 8'h80, 8'h80, 4'h8);
    rd_chk(18'h0001A, 8'hFF, 8'h69, 4'h8);
    rd_chk(18'h0001B, 8'hFF, 8'h27, 4'h8);
    master.write_cyc(18'h0001B, 8'h00);
    rd_chk(18'h0001B, 8'hFF, 8'h27, 4'h8);
    rd_chk(18'h00400, 8'hFF, 8'h00, 4'h0);
    master.write_cyc(18'h00013, 8'h01);
    rd_chk(18'h00400, 8'h00, 8'h00, 4'h4);
    rd_chk(18'h0047F, 8'h00, 8'h00, 4'h4);
    rd_chk(18'h003FF, 8'h00, 8'h00, 4'h8);
    rd_chk(18'h00800, 8'h00, 8'h00, 4'h2);
    rd_chk(18'h00FFF, 8'h00, 8'h00, 4'h2);
    rd_chk(18'h38000, 8'h00, 8'h00, 4'h1);
    rd_chk(18'h3FFFF, 8'h00, 8'h00, 4'h1);
    `CHK(illegal_reset_req, 1'b0)
    master.write_cyc(18'h0003C, 8'hFF);
    master.write_cyc(18'h0003B, 8'h04);
    rd_chk(18'h0003A, 8'h04, 8'h00, 4'h8);
    `CHK(irq, 1'b0)
    master.write_cyc(18'h01000, 8'h55);
    rd_chk(18'h01000, 8'hFF, 8'h00, 4'h0);
    rd_chk(18'h37FFF, 8'hFF, 8'h00, 4'h0);
    rd_chk(18'h0003A, 8'h04, 8'h04, 4'h8);
    `CHK(irq, 1'b1)
    master.write_cyc(18'h0003B, 8'h00);
    #1;
    `CHK(irq, 1'b0)
    master.write_cyc(18'h0003B, 8'h04);
    master.write_cyc(18'h0003C, 8'h04);
    #1;
    `CHK(irq, 1'b0)
    rd_chk(18'h0003A, 8'h04, 8'h00, 4'h8);
    master.write_cyc(18'h00039, 8'h01);
    #1;
    `CHK(clock_src_osc, 1'b1)
    `CHK(flash_clk_is_bus, 1'b1)
    `CHK(monitor_reset_req, 1'b0)
    // With the oscillator stopped the monitor must give up within 40 cycles of the enable write.
    @(posedge clk);
    osc_run <= 1'b0;
    master.write_cyc(18'h00039, 8'h03);
    n = 0;
    while (monitor_reset_req !== 1'b1 && n < 40)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    `CHK(monitor_reset_req, 1'b1)
    master.write_cyc(18'h00039, 8'h00);
    osc_run <= 1'b1;
    rd_chk(18'h0003A, 8'h02, 8'h02, 4'h8);
    finish_test();
  end
endmodule : tb_top
